// File: fswd_pkg.sv
// Purpose: constants and types for the flash settings write decoder
// Assumes: 64-byte command reports arrive one byte per cycle, byte 0 first
// Notes:   chip-settings bytes 2 to 4 are decoded; other payloads are passed to storage raw
//
// Overview of operation
// - byte 1 selects target: chip, pin power-up, three descriptor strings.
// - unknown selector: no write, response byte 1 carries unsupported code.
// - bytes 2 to 63 are the payload, its format set by selector.
// - byte 2 bit 7 enables the serial-number descriptor at enumeration.
// - byte 2 bit 6 is receive indicator idle level, inverted while receiving.
// - byte 2 bit 5 is transmit indicator idle level, inverted while sending.
// - byte 2 bit 4 is two-wire indicator idle level, inverted during traffic.
// - byte 2 bit 3 is suspend indicator level, inverted in suspend.
// - byte 2 bit 2 is configured indicator level, inverted once configured.
// - byte 2 bits 1-0 set security: 1x locked, 01 password, 00 open.
// - byte 3 bits 4-0 divide the 48 MHz clock for clock output.
// - byte 4 bits 7-6 choose internal reference level, 00 is off.
// - byte 4 bit 5 picks supply rail or the internal reference.
// - byte 4 bits 4-0 are the power-up output code of the converter.
package fswd_pkg;
    localparam logic [7:0] FSWD_CMD_WRITE     = 8'hB1;
    localparam logic [7:0] FSWD_SEL_CHIP      = 8'h00;
    localparam logic [7:0] FSWD_SEL_GP        = 8'h01;
    localparam logic [7:0] FSWD_SEL_MFR       = 8'h02;
    localparam logic [7:0] FSWD_SEL_PROD      = 8'h03;
    localparam logic [7:0] FSWD_SEL_SERIAL    = 8'h04;
    localparam logic [7:0] FSWD_STAT_OK       = 8'h00;
    localparam logic [7:0] FSWD_STAT_UNSUPP   = 8'h01;
    localparam int         FSWD_REPORT_LEN    = 64;
    localparam logic [5:0] FSWD_IDX_CMD       = 6'h00;
    localparam logic [5:0] FSWD_IDX_SEL       = 6'h01;
    localparam logic [5:0] FSWD_IDX_FLAGS     = 6'h02;
    localparam logic [5:0] FSWD_IDX_CLKDIV    = 6'h03;
    localparam logic [5:0] FSWD_IDX_DAC       = 6'h04;
    localparam logic [5:0] FSWD_IDX_LAST      = 6'h3F;
    localparam int         FSWD_BIT_SERIAL_EN = 7;
    localparam int         FSWD_BIT_RX_IDLE   = 6;
    localparam int         FSWD_BIT_TX_IDLE   = 5;
    localparam int         FSWD_BIT_TW_IDLE   = 4;
    localparam int         FSWD_BIT_SUSP_IDLE = 3;
    localparam int         FSWD_BIT_CFG_IDLE  = 2;
    localparam int         FSWD_BIT_REF_VDD   = 5;
    localparam logic [7:0] FSWD_RST_FLAGS     = 8'h00;
    localparam logic [4:0] FSWD_RST_CLKDIV    = 5'h01;
    localparam logic [7:0] FSWD_RST_DAC       = 8'h00;
    localparam logic [1:0] FSWD_SEC_OPEN      = 2'h0;
    localparam logic [1:0] FSWD_SEC_PASSWORD  = 2'h1;
    localparam logic [5:0] FSWD_CLKDIV_CYCLES = 6'h05;

    typedef enum logic [1:0] {
        FSWD_SEC_OPEN_MODE,
        FSWD_SEC_PW_MODE,
        FSWD_SEC_LOCKED_MODE
    } fswd_sec_type;
endpackage : fswd_pkg

// File: fswd_indicator.sv
// Purpose: one indicator pin: idle level, inverted while its event is active
// Assumes: active input is already synchronous to clk_i
// Notes:   enable low keeps the pin at idle level
`timescale 1ns/1ps
`default_nettype none
module fswd_indicator
    import fswd_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // control
    input  wire logic idle_level_i,
    input  wire logic enable_i,
    input  wire logic active_i,
    // pin
    output logic      pin_o
);
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_o <= 1'b0;
        end else begin
            pin_o <= (enable_i && active_i) ? ~idle_level_i : idle_level_i;
        end
    end

    chk_pin_inverts: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (enable_i && active_i) |=> (pin_o == ~$past(idle_level_i)))
        else $error("indicator not inverted while active");
    chk_pin_idles: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !(enable_i && active_i) |=> (pin_o == $past(idle_level_i)))
        else $error("indicator not at idle level");
endmodule : fswd_indicator
`default_nettype wire

// File: fswd_clkdiv.sv
// Purpose: divides the reference clock enable by twice the stored divider value
// Assumes: ref_tick_i marks each 48 MHz reference period
// Notes:   divider 0 and 1 both toggle the output on every reference tick
`timescale 1ns/1ps
`default_nettype none
module fswd_clkdiv
    import fswd_pkg::*;
#(
    parameter int DIV_W = 5
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // control
    input  wire logic             enable_i,
    input  wire logic [DIV_W-1:0] divider_i,
    input  wire logic             ref_tick_i,
    // output
    output logic                  clk_out_o
);
    localparam logic [DIV_W-1:0] DIV_ONE = DIV_W'(1);

    logic [DIV_W-1:0] count_r;

    // toggle on each terminal count: out period is 2*divider ticks
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_r   <= '0;
            clk_out_o <= 1'b0;
        end else if (!enable_i) begin
            count_r   <= '0;
            clk_out_o <= 1'b0;
        end else if (ref_tick_i) begin
            if (count_r + DIV_ONE >= divider_i) begin
                count_r   <= '0;
                clk_out_o <= ~clk_out_o;
            end else begin
                count_r <= count_r + DIV_ONE;
            end
        end
    end

    chk_div_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !enable_i |=> !clk_out_o)
        else $error("clock output active while disabled");
endmodule : fswd_clkdiv
`default_nettype wire

// File: fswd_decoder.sv
// Purpose: decodes write-flash command reports and holds chip settings
// Assumes: report bytes stream in order with a start marker on byte 0
// Notes:   a report cut short by a new start is dropped without response
`timescale 1ns/1ps
`default_nettype none
module fswd_decoder
    import fswd_pkg::*;
#(
    parameter int DIV_W = 5
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // command report stream
    input  wire logic             rpt_valid_i,
    input  wire logic             rpt_first_i,
    input  wire logic [7:0]       rpt_data_i,
    // response report stream
    output logic                  rsp_valid_o,
    output logic                  rsp_first_o,
    output logic [7:0]            rsp_data_o,
    // raw payload to flash storage
    output logic                  store_valid_o,
    output logic [7:0]            store_sel_o,
    output logic [5:0]            store_idx_o,
    output logic [7:0]            store_data_o,
    output logic                  store_done_o,
    // events from the rest of the device
    input  wire logic             uart_rx_busy_i,
    input  wire logic             uart_tx_busy_i,
    input  wire logic             twowire_busy_i,
    input  wire logic             suspend_i,
    input  wire logic             configured_i,
    input  wire logic             twowire_ind_en_i,
    input  wire logic             suspend_ind_en_i,
    input  wire logic             configured_ind_en_i,
    input  wire logic             clk_out_en_i,
    input  wire logic             ref_tick_i,
    // settings and pins
    output logic                  serial_desc_en_o,
    output fswd_sec_type          security_o,
    output logic [DIV_W-1:0]      clk_divider_o,
    output logic [1:0]            dac_ref_level_o,
    output logic                  dac_ref_supply_o,
    output logic [4:0]            dac_powerup_code_o,
    output logic                  rx_activity_indicator_o,
    output logic                  tx_activity_indicator_o,
    output logic                  twowire_activity_indicator_o,
    output logic                  suspend_indicator_o,
    output logic                  configured_indicator_o,
    output logic                  clk_out_o
);
    typedef enum logic [1:0] {
        FSWD_IDLE,
        FSWD_RECV,
        FSWD_DROP,
        FSWD_RESP
    } fswd_state_type;

    fswd_state_type state_r;
    logic [5:0]     idx_r;
    logic [5:0]     rsp_idx_r;
    logic [7:0]     sel_r;
    logic [7:0]     status_r;
    logic [7:0]     flags_r;
    logic [7:0]     flags_nxt_r;
    logic [4:0]     clkdiv_r;
    logic [4:0]     clkdiv_nxt_r;
    logic [7:0]     dac_r;
    logic [7:0]     dac_nxt_r;
    logic           sel_known;
    logic           in_payload;

    assign sel_known  = (rpt_data_i <= FSWD_SEL_SERIAL);
    assign in_payload = (state_r == FSWD_RECV) && rpt_valid_i && !rpt_first_i
                        && (idx_r >= FSWD_IDX_FLAGS);

    // report framing and response sequencing
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r   <= FSWD_IDLE;
            idx_r     <= '0;
            rsp_idx_r <= '0;
            sel_r     <= '0;
            status_r  <= FSWD_STAT_OK;
        end else begin
            case (state_r)
                FSWD_IDLE, FSWD_RECV, FSWD_DROP: begin
                    if (rpt_valid_i && rpt_first_i) begin
                        idx_r   <= 6'h01;
                        state_r <= (rpt_data_i == FSWD_CMD_WRITE) ? FSWD_RECV : FSWD_DROP;
                    end else if (rpt_valid_i && state_r != FSWD_IDLE) begin
                        if (idx_r == FSWD_IDX_SEL && state_r == FSWD_RECV) begin
                            sel_r    <= rpt_data_i;
                            status_r <= sel_known ? FSWD_STAT_OK : FSWD_STAT_UNSUPP;
                        end
                        if (idx_r == FSWD_IDX_LAST) begin
                            state_r   <= (state_r == FSWD_RECV) ? FSWD_RESP : FSWD_IDLE;
                            rsp_idx_r <= '0;
                        end else begin
                            idx_r <= idx_r + 6'h01;
                        end
                    end
                end
                FSWD_RESP: begin
                    if (rsp_idx_r == FSWD_IDX_LAST) begin
                        state_r <= FSWD_IDLE;
                    end
                    rsp_idx_r <= rsp_idx_r + 6'h01;
                end
                default: state_r <= FSWD_IDLE;
            endcase
        end
    end

    // response bytes: echo, status, then zeros
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rsp_valid_o <= 1'b0;
            rsp_first_o <= 1'b0;
            rsp_data_o  <= '0;
        end else begin
            rsp_valid_o <= (state_r == FSWD_RESP);
            rsp_first_o <= (state_r == FSWD_RESP) && (rsp_idx_r == FSWD_IDX_CMD);
            if (state_r != FSWD_RESP) begin
                rsp_data_o <= '0;
            end else if (rsp_idx_r == FSWD_IDX_CMD) begin
                rsp_data_o <= FSWD_CMD_WRITE;
            end else if (rsp_idx_r == FSWD_IDX_SEL) begin
                rsp_data_o <= status_r;
            end else begin
                rsp_data_o <= '0;
            end
        end
    end

    // raw payload to storage, suppressed for unknown selectors
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            store_valid_o <= 1'b0;
            store_sel_o   <= '0;
            store_idx_o   <= '0;
            store_data_o  <= '0;
        end else begin
            store_valid_o <= in_payload && (status_r == FSWD_STAT_OK);
            store_sel_o   <= sel_r;
            store_idx_o   <= idx_r;
            store_data_o  <= rpt_data_i;
        end
    end

    // chip-settings bytes staged, committed only on complete report
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags_nxt_r  <= FSWD_RST_FLAGS;
            clkdiv_nxt_r <= FSWD_RST_CLKDIV;
            dac_nxt_r    <= FSWD_RST_DAC;
        end else if (in_payload && sel_r == FSWD_SEL_CHIP) begin
            if (idx_r == FSWD_IDX_FLAGS) begin
                flags_nxt_r <= rpt_data_i;
            end else if (idx_r == FSWD_IDX_CLKDIV) begin
                clkdiv_nxt_r <= rpt_data_i[4:0];
            end else if (idx_r == FSWD_IDX_DAC) begin
                dac_nxt_r <= rpt_data_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags_r      <= FSWD_RST_FLAGS;
            clkdiv_r     <= FSWD_RST_CLKDIV;
            dac_r        <= FSWD_RST_DAC;
            store_done_o <= 1'b0;
        end else begin
            store_done_o <= (state_r == FSWD_RECV) && rpt_valid_i && !rpt_first_i
                            && (idx_r == FSWD_IDX_LAST) && (status_r == FSWD_STAT_OK);
            if ((state_r == FSWD_RECV) && rpt_valid_i && !rpt_first_i && (idx_r == FSWD_IDX_LAST)
                && (sel_r == FSWD_SEL_CHIP)) begin
                flags_r  <= flags_nxt_r;
                clkdiv_r <= clkdiv_nxt_r;
                dac_r    <= dac_nxt_r;
            end
        end
    end

    // decoded settings outputs
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            serial_desc_en_o   <= 1'b0;
            security_o         <= FSWD_SEC_OPEN_MODE;
            clk_divider_o      <= '0;
            dac_ref_level_o    <= '0;
            dac_ref_supply_o   <= 1'b0;
            dac_powerup_code_o <= '0;
        end else begin
            serial_desc_en_o <= flags_r[FSWD_BIT_SERIAL_EN];
            if (flags_r[1]) begin
                security_o <= FSWD_SEC_LOCKED_MODE;
            end else if (flags_r[1:0] == FSWD_SEC_PASSWORD) begin
                security_o <= FSWD_SEC_PW_MODE;
            end else begin
                security_o <= FSWD_SEC_OPEN_MODE;
            end
            clk_divider_o      <= DIV_W'(clkdiv_r);
            dac_ref_level_o    <= dac_r[7:6];
            dac_ref_supply_o   <= dac_r[FSWD_BIT_REF_VDD];
            dac_powerup_code_o <= dac_r[4:0];
        end
    end

    // indicator pins, one per event; rx and tx have no enable of their own
    logic [4:0] ind_idle;
    logic [4:0] ind_en;
    logic [4:0] ind_act;
    logic [4:0] ind_pin;

    assign ind_idle = flags_r[FSWD_BIT_RX_IDLE:FSWD_BIT_CFG_IDLE];
    assign ind_en   = {2'h3, twowire_ind_en_i, suspend_ind_en_i, configured_ind_en_i};
    assign ind_act  = {uart_rx_busy_i, uart_tx_busy_i, twowire_busy_i, suspend_i, configured_i};
    assign {rx_activity_indicator_o, tx_activity_indicator_o, twowire_activity_indicator_o,
            suspend_indicator_o, configured_indicator_o} = ind_pin;

    for (genvar g = 0; g < 5; g++) begin : g_ind
        fswd_indicator u_ind (
            .clk_i        (clk_i),
            .rst_n_i      (rst_n_i),
            .idle_level_i (ind_idle[g]),
            .enable_i     (ind_en[g]),
            .active_i     (ind_act[g]),
            .pin_o        (ind_pin[g])
        );
    end

    fswd_clkdiv #(
        .DIV_W (5)
    ) u_clkdiv (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .enable_i   (clk_out_en_i),
        .divider_i  (clkdiv_r),
        .ref_tick_i (ref_tick_i),
        .clk_out_o  (clk_out_o)
    );

    chk_unsupp_nowrite: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (status_r == FSWD_STAT_UNSUPP) |-> !store_valid_o)
        else $error("write issued for unsupported selector");
    chk_resp_echo: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rsp_valid_o && rsp_first_o) |-> (rsp_data_o == FSWD_CMD_WRITE)
            ##1 (rsp_valid_o && rsp_data_o == $past(status_r)))
        else $error("response header wrong");
    chk_resp_length: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(rsp_first_o) |-> rsp_valid_o [*8])
        else $error("response report ended early");
    chk_bad_cmd_drop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_r != FSWD_RESP && rpt_valid_i && rpt_first_i && rpt_data_i != FSWD_CMD_WRITE)
            |=> (state_r == FSWD_DROP))
        else $error("foreign command not dropped");
    chk_security_map: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        flags_r[1] |=> (security_o == FSWD_SEC_LOCKED_MODE))
        else $error("lock code not decoded");
    chk_dac_fields: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        1'b1 |=> (dac_powerup_code_o == $past(dac_r[4:0]) && dac_ref_level_o == $past(dac_r[7:6])))
        else $error("dac fields misdecoded");
    chk_serial_en: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        1'b1 |=> (serial_desc_en_o == $past(flags_r[FSWD_BIT_SERIAL_EN])))
        else $error("serial enable misdecoded");
    chk_store_range: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        store_valid_o
            |-> (store_idx_o >= FSWD_IDX_FLAGS))
        else $error("store pulse outside payload bytes");
    chk_store_known: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        store_valid_o
            |-> (store_sel_o <= FSWD_SEL_SERIAL))
        else $error("store pulse for unknown selector");
    chk_done_last: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        store_done_o
            |-> (store_valid_o && store_idx_o == FSWD_IDX_LAST))
        else $error("store done not on last payload byte");
    chk_resp_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rsp_valid_o && !rsp_first_o && !$past(rsp_first_o))
            |-> (rsp_data_o == 8'h00))
        else $error("response padding not zero");
    chk_first_once: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rsp_first_o
            |=> !rsp_first_o)
        else $error("response start marker repeated");
    chk_sec_password: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (flags_r[1:0] == FSWD_SEC_PASSWORD)
            |=> (security_o == FSWD_SEC_PW_MODE))
        else $error("password code not decoded");
    chk_sec_open: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (flags_r[1:0] == FSWD_SEC_OPEN)
            |=> (security_o == FSWD_SEC_OPEN_MODE))
        else $error("open code not decoded");
    chk_cmd_accept: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_r != FSWD_RESP && rpt_valid_i && rpt_first_i && rpt_data_i == FSWD_CMD_WRITE)
            |=> (state_r == FSWD_RECV))
        else $error("write command not accepted");
    chk_unknown_status: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_r == FSWD_RECV && rpt_valid_i && !rpt_first_i && idx_r == FSWD_IDX_SEL
            && rpt_data_i > FSWD_SEL_SERIAL) |=> (status_r == FSWD_STAT_UNSUPP))
        else $error("unknown selector not flagged");
endmodule : fswd_decoder
`default_nettype wire

// File: fswd_host_model.sv
// Purpose: host side model that streams 64-byte command reports
// Assumes: one byte per cycle, changed on the falling clock edge
// Notes:   data line shows inverted last byte once released
`timescale 1ns/1ps
`default_nettype none
module fswd_host_model
    import fswd_pkg::*;
(
    // clock
    input  wire logic       clk_i,
    // report stream
    output logic            rpt_valid_o,
    output logic            rpt_first_o,
    output logic [7:0]      rpt_data_o
);
    initial begin
        rpt_valid_o = 1'b0;
        rpt_first_o = 1'b0;
        rpt_data_o  = 8'h00;
    end

    // command code sits in byte 0, payload follows in order
    task automatic send_report(input logic [7:0] rpt [64]);
        for (int i = 0; i < FSWD_REPORT_LEN; i++) begin
            @(negedge clk_i);
            rpt_valid_o = 1'b1;
            rpt_first_o = (i == 0);
            rpt_data_o  = rpt[i];
        end
        @(negedge clk_i);
        rpt_valid_o = 1'b0;
        rpt_first_o = 1'b0;
        rpt_data_o  = ~rpt_data_o;
    endtask : send_report
endmodule : fswd_host_model
`default_nettype wire

// File: tb_flash_settings_write_decoder.sv
// Purpose: self-checking bench for the settings write decoder
// Assumes: inputs change and outputs are sampled on the falling edge
// Notes:   reports come from the host model; events are driven here
`timescale 1ns/1ps
`default_nettype none
module tb_flash_settings_write_decoder
    import fswd_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic rpt_valid, rpt_first, rsp_valid_o, rsp_first_o, store_valid_o, store_done_o;
    logic [7:0] rpt_data, rsp_data_o, store_sel_o, store_data_o;
    logic [5:0] store_idx_o;
    logic rxb = 0, txb = 0, twb = 0, susp = 0, cfg = 0, twen = 0, spen = 0, cfen = 0, coen = 0, tick = 0;
    logic serial_desc_en_o, dac_ref_supply_o, rx_o, tx_o, tw_o, sp_o, cf_o, clk_out_o;
    fswd_sec_type security_o;
    logic [4:0] clk_divider_o, dac_powerup_code_o;
    logic [1:0] dac_ref_level_o;
    logic [7:0] rpt [64];
    logic [7:0] rsp_buf [64];
    int errors = 0, total_checks = 0, rsp_cnt, ridx, st_cnt, st_bad, done_cnt;

    always #2 clk_i = ~clk_i;

    fswd_host_model host (.clk_i(clk_i), .rpt_valid_o(rpt_valid), .rpt_first_o(rpt_first), .rpt_data_o(rpt_data));

    fswd_decoder uut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .rpt_valid_i(rpt_valid), .rpt_first_i(rpt_first),
        .rpt_data_i(rpt_data), .rsp_valid_o(rsp_valid_o), .rsp_first_o(rsp_first_o), .rsp_data_o(rsp_data_o),
        .store_valid_o(store_valid_o), .store_sel_o(store_sel_o), .store_idx_o(store_idx_o),
        .store_data_o(store_data_o), .store_done_o(store_done_o), .uart_rx_busy_i(rxb), .uart_tx_busy_i(txb),
        .twowire_busy_i(twb), .suspend_i(susp), .configured_i(cfg), .twowire_ind_en_i(twen),
        .suspend_ind_en_i(spen), .configured_ind_en_i(cfen), .clk_out_en_i(coen), .ref_tick_i(tick),
        .serial_desc_en_o(serial_desc_en_o), .security_o(security_o), .clk_divider_o(clk_divider_o),
        .dac_ref_level_o(dac_ref_level_o), .dac_ref_supply_o(dac_ref_supply_o),
        .dac_powerup_code_o(dac_powerup_code_o), .rx_activity_indicator_o(rx_o), .tx_activity_indicator_o(tx_o),
        .twowire_activity_indicator_o(tw_o), .suspend_indicator_o(sp_o), .configured_indicator_o(cf_o),
        .clk_out_o(clk_out_o)
    );

    // response and store monitors, mid-cycle so outputs have settled
    always @(negedge clk_i) begin
        if (rsp_valid_o === 1'b1) begin
            if (rsp_first_o === 1'b1) ridx = 0;
            if (ridx < 64) rsp_buf[ridx] = rsp_data_o;
            ridx++;
            rsp_cnt++;
        end
        if (store_valid_o === 1'b1) begin
            if (store_idx_o !== 6'(st_cnt + 2) || store_data_o !== rpt[st_cnt + 2] || store_sel_o !== rpt[1])
                st_bad++;
            st_cnt++;
        end
        if (store_done_o === 1'b1) done_cnt++;
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    task automatic run(input logic [7:0] cmd, input logic [7:0] sel, input logic [7:0] b2,
                       input logic [7:0] b3, input logic [7:0] b4);
        int  k;
        logic known;
        known = (sel <= FSWD_SEL_SERIAL) && (cmd == FSWD_CMD_WRITE);
        rpt[0] = cmd;
        rpt[1] = sel;
        rpt[2] = b2;
        rpt[3] = b3;
        rpt[4] = b4;
        for (k = 5; k < 64; k++) rpt[k] = 8'(k * 3);
        rsp_cnt = 0; st_cnt = 0; st_bad = 0; done_cnt = 0; ridx = 0;
        host.send_report(rpt);
        for (k = 0; k < 300 && !(rsp_cnt == 64 && rsp_valid_o === 1'b0); k++) @(negedge clk_i);
        if (k == 300 && cmd == FSWD_CMD_WRITE) begin
            errors++;
            $display("mismatch rsp_wait expected done seen timeout");
            summarize();
        end
        if (cmd == FSWD_CMD_WRITE) begin
            chk("rsp_count", 8'h40, 8'(rsp_cnt));
            chk("rsp_echo", cmd, rsp_buf[0]);
            chk("rsp_status", (sel <= FSWD_SEL_SERIAL) ? FSWD_STAT_OK : FSWD_STAT_UNSUPP, rsp_buf[1]);
        end else chk("rsp_count", 8'h00, 8'(rsp_cnt));
        chk("store_count", known ? 8'h3E : 8'h00, 8'(st_cnt));
        chk("store_fields", 8'h00, 8'(st_bad));
        chk("store_done", known ? 8'h01 : 8'h00, 8'(done_cnt));
        $display("test report %h/%h done", cmd, sel);
    endtask : run

    task automatic chip_chk(input logic [7:0] b2, input logic [7:0] b3, input logic [7:0] b4);
        fswd_sec_type s;
        if (b2[1]) s = FSWD_SEC_LOCKED_MODE;
        else if (b2[0]) s = FSWD_SEC_PW_MODE;
        else s = FSWD_SEC_OPEN_MODE;
        chk("serial_desc", {7'h00, b2[7]}, {7'h00, serial_desc_en_o});
        chk("security", {6'h00, s}, {6'h00, security_o});
        chk("clk_divider", {3'h0, b3[4:0]}, {3'h0, clk_divider_o});
        chk("dac_level", {6'h00, b4[7:6]}, {6'h00, dac_ref_level_o});
        chk("dac_supply", {7'h00, b4[5]}, {7'h00, dac_ref_supply_o});
        chk("dac_code", {3'h0, b4[4:0]}, {3'h0, dac_powerup_code_o});
        chk("idle_pins", {3'h0, b2[6:2]}, {3'h0, rx_o, tx_o, tw_o, sp_o, cf_o});
    endtask : chip_chk

    logic [7:0] b2t [4] = '{8'hD4, 8'h29, 8'h8A, 8'h7F};
    logic [7:0] b3t [4] = '{8'hE7, 8'h41, 8'h1F, 8'h02};
    logic [7:0] b4t [4] = '{8'hB5, 8'h40, 8'hFF, 8'h1A};
    logic v;
    int k;

    initial begin
        repeat (12) @(negedge clk_i);
        rst_n_i = 1'b1;
        @(negedge clk_i);
        chk("rst_divider", {3'h0, FSWD_RST_CLKDIV}, {3'h0, clk_divider_o});
        chk("rst_pins", 8'h00, {3'h0, rx_o, tx_o, tw_o, sp_o, cf_o});
        for (int i = 0; i < 4; i++) begin
            run(FSWD_CMD_WRITE, FSWD_SEL_CHIP, b2t[i], b3t[i], b4t[i]);
            chip_chk(b2t[i], b3t[i], b4t[i]);
            if (i == 0) begin
                {rxb, txb, twb, susp, cfg, twen, spen, cfen} = 8'hFF;
                repeat (3) @(negedge clk_i);
                chk("active_pins", {3'h0, ~b2t[0][6:2]}, {3'h0, rx_o, tx_o, tw_o, sp_o, cf_o});
                {twen, spen, cfen} = 3'b000;
                repeat (3) @(negedge clk_i);
                chk("disabled_pins", {3'h0, ~b2t[0][6:5], b2t[0][4:2]},
                    {3'h0, rx_o, tx_o, tw_o, sp_o, cf_o});
                {rxb, txb, twb, susp, cfg} = 5'b00000;
                repeat (3) @(negedge clk_i);
            end
        end
        for (int s = 1; s < 5; s++) run(FSWD_CMD_WRITE, 8'(s), 8'h00, 8'h00, 8'h00);
        run(FSWD_CMD_WRITE, 8'h05, 8'h00, 8'h00, 8'h00);
        run(FSWD_CMD_WRITE, 8'hFF, 8'h00, 8'h00, 8'h00);
        run(8'hB0, FSWD_SEL_CHIP, 8'h00, 8'h00, 8'h00);
        chip_chk(b2t[3], b3t[3], b4t[3]);
        coen = 1'b1;
        tick = 1'b1;
        v = clk_out_o;
        for (k = 0; k < 20 && clk_out_o === v; k++) @(negedge clk_i);
        v = clk_out_o;
        for (k = 0; k < 20 && clk_out_o === v; k++) @(negedge clk_i);
        chk("clk_half_period", 8'h02, 8'(k));
        coen = 1'b0;
        repeat (4) @(negedge clk_i);
        chk("clk_out_off", 8'h00, {7'h00, clk_out_o});
        $display("test clock output done");
        summarize();
    end
endmodule : tb_flash_settings_write_decoder
`default_nettype wire
